// ### cpt_pkg.sv
// Package of the counter and pulse timer unit: register map, field layout,
// reset values, modes and cycle counts shared by the design files.
// Assumes a 40 MHz system clock and a 32-bit AXI4-Lite register bus.
package cpt_pkg;

  // Clock and time base
  localparam int CLK_HZ = 40_000_000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int TB_HZ = 20_000_000;
  localparam int TB_CYCLES = CLK_HZ / TB_HZ;
  localparam int UNIT_TIME_NS = 50_000;
  localparam int UNIT_CYCLES = UNIT_TIME_NS / CLK_PERIOD_NS;
  localparam int GATE_TIME_MS = 1000;
  localparam int GATE_CYCLES = GATE_TIME_MS * (CLK_HZ / 1000);

  // Limits on programmed durations
  localparam logic [31:0] PWM_MIN_UNITS = 32'h0000_0002;
  localparam logic [31:0] TIMER_MIN_DIV = 32'h0000_0004;

  // Register map (byte addresses)
  localparam int ADDR_W = 12;
  localparam logic [11:0] REG_IRQ_STATUS = 12'h000;
  localparam logic [11:0] REG_IRQ_MASK = 12'h004;
  localparam logic [11:0] CH_BASE = 12'h040;
  localparam int CH_STRIDE_SHIFT = 5;
  // Word index inside one channel window
  localparam logic [2:0] CH_CTRL = 3'h0;
  localparam logic [2:0] CH_MATCH = 3'h1;
  localparam logic [2:0] CH_VALUE = 3'h2;
  localparam logic [2:0] CH_HIGH = 3'h3;
  localparam logic [2:0] CH_LOW = 3'h4;
  localparam logic [2:0] CH_DIV = 3'h5;

  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_FALLING = 3;
  localparam int CTRL_ENABLE = 4;
  localparam int CTRL_LOW_LEVEL = 5;
  localparam int CTRL_SINGLE = 6;
  localparam int CTRL_MATCH_IE = 7;
  localparam int CTRL_W = 8;

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [31:0] MATCH_RST = 32'h0000_0000;
  localparam logic [31:0] HIGH_RST = 32'h0000_0002;
  localparam logic [31:0] LOW_RST = 32'h0000_0002;
  localparam logic [31:0] DIV_RST = 32'h0000_0004;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    MODE_EVENT = 3'h0,
    MODE_FREQ = 3'h1,
    MODE_WIDTH = 3'h2,
    MODE_PWM = 3'h3,
    MODE_TIMER = 3'h4
  } cpt_mode_t;

  typedef enum logic [1:0] {
    PH_IDLE = 2'h0,
    PH_HIGH = 2'h1,
    PH_LOW = 2'h3,
    PH_DONE = 2'h2
  } cpt_phase_t;

  typedef enum logic [1:0] {
    WM_SEEK = 2'h0,
    WM_ARMED = 2'h1,
    WM_MEAS = 2'h3
  } cpt_wm_t;

endpackage

// ### cpt_sync.sv
// Two-stage synchroniser for a group of asynchronous level inputs.
// Assumes the inputs change slower than the clock; no filtering is done.
`timescale 1ns/1ps
module cpt_sync #(
  parameter int W = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      q_o <= '0;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule

// ### cpt_top.sv
// Counter and pulse timer unit: per channel event counting, frequency and
// pulse width measurement, PWM / pulse output and periodic timer output,
// with an AXI4-Lite register slave and a sticky, maskable interrupt.
// Assumes counter inputs are asynchronous pins and one 40 MHz clock.
// Function
// - Event mode counts input pulses; running total readable as counter value.
// - Each channel selects counting on rising or on falling input edges.
// - With match interrupt enabled, reaching match value raises an interrupt.
// - Counting continues past match; overflow wraps to zero and keeps counting.
// - Frequency mode measures input frequency and reports it as readable value.
// - Width mode measures high or low time, 50 ns to 214 s.
// - Output high and low durations programmable, 2 to 2^32-1 units of 50 us.
// - Channel produces single pulse, pulse train, or PWM waveform.
// - Timer mode divides 20 MHz base, pulses output and interrupt each terminal count.
// - Timer output spans 0.005 Hz to 5 MHz; divide ratio four is the top.
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module cpt_top #(
  parameter int NUM_CH = 2,
  parameter int unsigned GATE_CYCLES = cpt_pkg::GATE_CYCLES
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic [11:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [11:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic [NUM_CH-1:0] CNT_IN_I,
  output logic [NUM_CH-1:0] CNT_OUT_O,
  output logic INT_O
);
  localparam int UNIT_W = $clog2(cpt_pkg::UNIT_CYCLES);
  localparam int TB_W = $clog2(cpt_pkg::TB_CYCLES);
  localparam int ST_W = 2 * NUM_CH;

  logic [NUM_CH-1:0] in_sync;
  logic [TB_W-1:0] tb_div_reg;
  logic tb_tick;
  logic [cpt_pkg::CTRL_W-1:0] ctrl_reg [NUM_CH];
  logic [31:0] match_reg [NUM_CH];
  logic [31:0] high_reg [NUM_CH];
  logic [31:0] low_reg [NUM_CH];
  logic [31:0] div_reg [NUM_CH];
  logic [31:0] value_w [NUM_CH];
  logic [NUM_CH-1:0] match_evt;
  logic [NUM_CH-1:0] tc_evt;
  logic [NUM_CH-1:0] out_w;
  logic [ST_W-1:0] status_reg;
  logic [ST_W-1:0] status_next;
  logic [ST_W-1:0] mask_reg;
  logic [ST_W-1:0] status_set;
  logic [ST_W-1:0] status_clr;
  logic aw_full_reg;
  logic w_full_reg;
  logic [11:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic do_wr;
  logic ar_hs;
  logic [31:0] rd_data;
  logic rd_ok;
  logic wr_ok;
  logic [11:0] wr_off;
  logic [11:0] rd_off;

  cpt_sync #(
    .W(NUM_CH)
  ) cpt_sync_i (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    .d_i(CNT_IN_I),
    .q_o(in_sync)
  );

  function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  // 20 MHz time base as an enable
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      tb_div_reg <= '0;
    end else begin
      tb_div_reg <= tb_tick ? '0 : tb_div_reg + TB_W'(1);
    end
  end
  assign tb_tick = (tb_div_reg == TB_W'(cpt_pkg::TB_CYCLES - 1));

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      logic [31:0] cnt_reg;
      logic [31:0] aux_reg;
      logic [31:0] gate_reg;
      logic [UNIT_W-1:0] pre_reg;
      logic unit_hit;
      logic prev_reg;
      cpt_pkg::cpt_phase_t ph_reg;
      cpt_pkg::cpt_wm_t wm_reg;
      cpt_pkg::cpt_mode_t mode;
      logic en;
      logic edge_hit;
      logic active;
      logic [31:0] hi_dur;
      logic [31:0] lo_dur;
      logic [31:0] div_eff;
      logic tc_hit;

      assign mode = cpt_pkg::cpt_mode_t'(ctrl_reg[g][cpt_pkg::CTRL_MODE_LSB +: 3]);
      assign en = ctrl_reg[g][cpt_pkg::CTRL_ENABLE];
      assign edge_hit = ctrl_reg[g][cpt_pkg::CTRL_FALLING] ? (prev_reg & ~in_sync[g])
                                                           : (~prev_reg & in_sync[g]);
      assign active = in_sync[g] ^ ctrl_reg[g][cpt_pkg::CTRL_LOW_LEVEL];
      // durations below two units are raised to two
      assign hi_dur = (high_reg[g] < cpt_pkg::PWM_MIN_UNITS) ? cpt_pkg::PWM_MIN_UNITS
                                                            : high_reg[g];
      assign lo_dur = (low_reg[g] < cpt_pkg::PWM_MIN_UNITS) ? cpt_pkg::PWM_MIN_UNITS
                                                           : low_reg[g];
      // ratio four caps the output at 5 MHz
      assign div_eff = (div_reg[g] < cpt_pkg::TIMER_MIN_DIV) ? cpt_pkg::TIMER_MIN_DIV
                                                            : div_reg[g];
      assign tc_hit = tb_tick && (aux_reg >= div_eff - 32'h0000_0001);
      // Own unit prescaler: a shared one would cut the first unit short
      assign unit_hit = (pre_reg == UNIT_W'(cpt_pkg::UNIT_CYCLES - 1));

      always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
          prev_reg <= 1'b0;
        end else begin
          prev_reg <= in_sync[g];
        end
      end

      always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
          cnt_reg <= '0;
          aux_reg <= '0;
          gate_reg <= '0;
          pre_reg <= '0;
          ph_reg <= cpt_pkg::PH_IDLE;
          wm_reg <= cpt_pkg::WM_SEEK;
        end else if (!en) begin
          cnt_reg <= '0;
          aux_reg <= '0;
          gate_reg <= '0;
          pre_reg <= '0;
          ph_reg <= cpt_pkg::PH_IDLE;
          wm_reg <= cpt_pkg::WM_SEEK;
        end else begin
          case (mode)
            cpt_pkg::MODE_EVENT: begin
              // plain wrap to zero on overflow
              if (edge_hit) begin
                cnt_reg <= cnt_reg + 32'h0000_0001;
              end
            end
            cpt_pkg::MODE_FREQ: begin
              // edges over a one-second gate give hertz
              if (gate_reg == 32'(GATE_CYCLES - 1)) begin
                cnt_reg <= aux_reg + {31'h0, edge_hit};
                aux_reg <= '0;
                gate_reg <= '0;
              end else begin
                aux_reg <= aux_reg + {31'h0, edge_hit};
                gate_reg <= gate_reg + 32'h0000_0001;
              end
            end
            cpt_pkg::MODE_WIDTH: begin
              // count 50 ns ticks while the chosen level holds
              case (wm_reg)
                cpt_pkg::WM_SEEK: begin
                  if (!active) begin
                    wm_reg <= cpt_pkg::WM_ARMED;
                  end
                end
                cpt_pkg::WM_ARMED: begin
                  if (active) begin
                    aux_reg <= '0;
                    wm_reg <= cpt_pkg::WM_MEAS;
                  end
                end
                cpt_pkg::WM_MEAS: begin
                  if (!active) begin
                    cnt_reg <= aux_reg;
                    wm_reg <= cpt_pkg::WM_ARMED;
                  end else if (tb_tick && aux_reg != 32'hFFFF_FFFF) begin
                    aux_reg <= aux_reg + 32'h0000_0001;
                  end
                end
                default: begin
                  wm_reg <= cpt_pkg::WM_SEEK;
                end
              endcase
            end
            cpt_pkg::MODE_PWM: begin
              // high then low phase, repeat unless single shot
              case (ph_reg)
                cpt_pkg::PH_IDLE: begin
                  aux_reg <= '0;
                  pre_reg <= '0;
                  ph_reg <= cpt_pkg::PH_HIGH;
                end
                cpt_pkg::PH_HIGH: begin
                  if (unit_hit) begin
                    pre_reg <= '0;
                    if (aux_reg + 32'h0000_0001 >= hi_dur) begin
                      aux_reg <= '0;
                      ph_reg <= cpt_pkg::PH_LOW;
                    end else begin
                      aux_reg <= aux_reg + 32'h0000_0001;
                    end
                  end else begin
                    pre_reg <= pre_reg + UNIT_W'(1);
                  end
                end
                cpt_pkg::PH_LOW: begin
                  if (!unit_hit) begin
                    pre_reg <= pre_reg + UNIT_W'(1);
                  end else begin
                    pre_reg <= '0;
                    if (aux_reg + 32'h0000_0001 >= lo_dur) begin
                      aux_reg <= '0;
                      cnt_reg <= cnt_reg + 32'h0000_0001;
                      ph_reg <= ctrl_reg[g][cpt_pkg::CTRL_SINGLE] ? cpt_pkg::PH_DONE
                                                                   : cpt_pkg::PH_HIGH;
                    end else begin
                      aux_reg <= aux_reg + 32'h0000_0001;
                    end
                  end
                end
                default: begin
                  ph_reg <= cpt_pkg::PH_DONE;
                end
              endcase
            end
            cpt_pkg::MODE_TIMER: begin
              // terminal count of the programmed ratio
              if (tc_hit) begin
                aux_reg <= '0;
                cnt_reg <= cnt_reg + 32'h0000_0001;
              end else if (tb_tick) begin
                aux_reg <= aux_reg + 32'h0000_0001;
              end
            end
            default: begin
              aux_reg <= '0;
            end
          endcase
        end
      end

      assign value_w[g] = cnt_reg;
      // match raised on the edge that reaches the value
      assign match_evt[g] = en && mode == cpt_pkg::MODE_EVENT && edge_hit &&
                            ctrl_reg[g][cpt_pkg::CTRL_MATCH_IE] &&
                            (cnt_reg + 32'h0000_0001 == match_reg[g]);
      assign tc_evt[g] = en && mode == cpt_pkg::MODE_TIMER && tc_hit;
      assign out_w[g] = (en && mode == cpt_pkg::MODE_PWM && ph_reg == cpt_pkg::PH_HIGH) ||
                        tc_evt[g];
      assign status_set[2*g] = match_evt[g];
      assign status_set[2*g+1] = tc_evt[g];
    end
  endgenerate

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      CNT_OUT_O <= '0;
    end else begin
      CNT_OUT_O <= out_w;
    end
  end

  // sticky flags, read clears, a new event wins
  assign status_clr = (ar_hs && S_AXI_ARADDR_I == cpt_pkg::REG_IRQ_STATUS) ? '1 : '0;
  assign status_next = (status_reg & ~status_clr) | status_set;

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      status_reg <= '0;
      INT_O <= 1'b0;
    end else begin
      status_reg <= status_next;
      INT_O <= |(status_next & mask_reg);
    end
  end

  // Write channel: address and data taken in either order
  assign do_wr = aw_full_reg && w_full_reg && !S_AXI_BVALID_O;
  assign wr_off = awaddr_reg - cpt_pkg::CH_BASE;
  assign wr_ok = (awaddr_reg[1:0] == 2'h0) &&
                 (awaddr_reg == cpt_pkg::REG_IRQ_STATUS ||
                  awaddr_reg == cpt_pkg::REG_IRQ_MASK ||
                  (awaddr_reg >= cpt_pkg::CH_BASE &&
                   32'(wr_off >> cpt_pkg::CH_STRIDE_SHIFT) < NUM_CH &&
                   wr_off[4:2] <= cpt_pkg::CH_DIV));

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      S_AXI_AWREADY_O <= 1'b1;
      S_AXI_WREADY_O <= 1'b1;
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O <= cpt_pkg::RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        aw_full_reg <= 1'b1;
        awaddr_reg <= S_AXI_AWADDR_I;
        S_AXI_AWREADY_O <= 1'b0;
      end else if (do_wr) begin
        aw_full_reg <= 1'b0;
        S_AXI_AWREADY_O <= 1'b1;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        w_full_reg <= 1'b1;
        wdata_reg <= S_AXI_WDATA_I;
        wstrb_reg <= S_AXI_WSTRB_I;
        S_AXI_WREADY_O <= 1'b0;
      end else if (do_wr) begin
        w_full_reg <= 1'b0;
        S_AXI_WREADY_O <= 1'b1;
      end
      if (do_wr) begin
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O <= wr_ok ? cpt_pkg::RESP_OKAY : cpt_pkg::RESP_SLVERR;
      end else if (S_AXI_BREADY_I) begin
        S_AXI_BVALID_O <= 1'b0;
      end
    end
  end

  // Software-written settings that steer the channels
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      mask_reg <= '0;
      for (int c = 0; c < NUM_CH; c++) begin
        ctrl_reg[c] <= cpt_pkg::CTRL_RST;
        match_reg[c] <= cpt_pkg::MATCH_RST;
        high_reg[c] <= cpt_pkg::HIGH_RST;
        low_reg[c] <= cpt_pkg::LOW_RST;
        div_reg[c] <= cpt_pkg::DIV_RST;
      end
    end else if (do_wr && wr_ok) begin
      if (awaddr_reg == cpt_pkg::REG_IRQ_MASK) begin
        mask_reg <= ST_W'(apply_strb(32'(mask_reg), wdata_reg, wstrb_reg));
      end
      for (int c = 0; c < NUM_CH; c++) begin
        if (awaddr_reg >= cpt_pkg::CH_BASE && 32'(wr_off >> cpt_pkg::CH_STRIDE_SHIFT) == c) begin
          case (wr_off[4:2])
            cpt_pkg::CH_CTRL: ctrl_reg[c] <= cpt_pkg::CTRL_W'(
                apply_strb(32'(ctrl_reg[c]), wdata_reg, wstrb_reg));
            cpt_pkg::CH_MATCH: match_reg[c] <= apply_strb(match_reg[c], wdata_reg, wstrb_reg);
            cpt_pkg::CH_HIGH: high_reg[c] <= apply_strb(high_reg[c], wdata_reg, wstrb_reg);
            cpt_pkg::CH_LOW: low_reg[c] <= apply_strb(low_reg[c], wdata_reg, wstrb_reg);
            cpt_pkg::CH_DIV: div_reg[c] <= apply_strb(div_reg[c], wdata_reg, wstrb_reg);
            default: begin
            end
          endcase
        end
      end
    end
  end

  // Read channel: data captured at the address handshake
  assign ar_hs = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  assign rd_off = S_AXI_ARADDR_I - cpt_pkg::CH_BASE;

  always_comb begin
    rd_data = '0;
    rd_ok = 1'b0;
    if (S_AXI_ARADDR_I == cpt_pkg::REG_IRQ_STATUS) begin
      rd_data = 32'(status_reg);
      rd_ok = 1'b1;
    end else if (S_AXI_ARADDR_I == cpt_pkg::REG_IRQ_MASK) begin
      rd_data = 32'(mask_reg);
      rd_ok = 1'b1;
    end else if (S_AXI_ARADDR_I >= cpt_pkg::CH_BASE && S_AXI_ARADDR_I[1:0] == 2'h0) begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (32'(rd_off >> cpt_pkg::CH_STRIDE_SHIFT) == c) begin
          rd_ok = (rd_off[4:2] <= cpt_pkg::CH_DIV);
          case (rd_off[4:2])
            cpt_pkg::CH_CTRL: rd_data = 32'(ctrl_reg[c]);
            cpt_pkg::CH_MATCH: rd_data = match_reg[c];
            cpt_pkg::CH_VALUE: rd_data = value_w[c];
            cpt_pkg::CH_HIGH: rd_data = high_reg[c];
            cpt_pkg::CH_LOW: rd_data = low_reg[c];
            cpt_pkg::CH_DIV: rd_data = div_reg[c];
            default: rd_data = '0;
          endcase
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      S_AXI_ARREADY_O <= 1'b1;
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O <= '0;
      S_AXI_RRESP_O <= cpt_pkg::RESP_OKAY;
    end else begin
      if (ar_hs) begin
        S_AXI_ARREADY_O <= 1'b0;
        S_AXI_RVALID_O <= 1'b1;
        S_AXI_RDATA_O <= rd_data;
        S_AXI_RRESP_O <= rd_ok ? cpt_pkg::RESP_OKAY : cpt_pkg::RESP_SLVERR;
      end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
        S_AXI_RVALID_O <= 1'b0;
        S_AXI_ARREADY_O <= 1'b1;
      end
    end
  end
endmodule

// ### cpt_chk.sv
// Checker for the counter unit: bus handshakes and sticky interrupt.
// Assumes it is bound to cpt_top and sees only its ports.
`timescale 1ns/1ps
module cpt_chk #(
  parameter int NUM_CH = 2
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic [11:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  input wire logic S_AXI_AWREADY_O,
  input wire logic S_AXI_WVALID_I,
  input wire logic S_AXI_WREADY_O,
  input wire logic [1:0] S_AXI_BRESP_O,
  input wire logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [11:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  input wire logic S_AXI_ARREADY_O,
  input wire logic [31:0] S_AXI_RDATA_O,
  input wire logic [1:0] S_AXI_RRESP_O,
  input wire logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic [NUM_CH-1:0] CNT_OUT_O,
  input wire logic INT_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  logic aw_t, w_t, ar_t;
  assign aw_t = S_AXI_AWVALID_I && S_AXI_AWREADY_O;
  assign w_t = S_AXI_WVALID_I && S_AXI_WREADY_O;
  assign ar_t = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  bresp_hold_a: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=>
    S_AXI_BVALID_O && $stable(S_AXI_BRESP_O)) else $error("write response dropped");
  rdata_hold_a: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=>
    S_AXI_RVALID_O && $stable(S_AXI_RDATA_O)) else $error("read data dropped");
  ar_block_a: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
    else $error("read address taken while data pending");
  rd_answer_a: assert property (ar_t |=> S_AXI_RVALID_O)
    else $error("read answer late");
  wr_answer_a: assert property (aw_t && w_t && !S_AXI_BVALID_O |=>
    !S_AXI_AWREADY_O ##1 S_AXI_BVALID_O) else $error("write answer late");
  wr_slverr_a: assert property (aw_t && w_t && !S_AXI_BVALID_O && S_AXI_AWADDR_I == 12'h008
    |=> ##1 S_AXI_BRESP_O == cpt_pkg::RESP_SLVERR) else $error("unmapped write accepted");
  rd_slverr_a: assert property (ar_t && S_AXI_ARADDR_I == 12'h008 |=>
    S_AXI_RRESP_O == cpt_pkg::RESP_SLVERR && S_AXI_RDATA_O == 32'h0)
    else $error("unmapped read accepted");
  // Only a status read or a mask write may lower the request
  int_sticky_a: assert property (INT_O && !S_AXI_ARVALID_I && !S_AXI_AWVALID_I
    && !S_AXI_WVALID_I && S_AXI_AWREADY_O && $past(S_AXI_AWREADY_O) |=> INT_O)
    else $error("interrupt lost without acknowledge");
  cover property (ar_t && S_AXI_ARADDR_I == cpt_pkg::REG_IRQ_STATUS && INT_O);
  cover property ($rose(CNT_OUT_O[0]));
  cover property ($fell(CNT_OUT_O[NUM_CH-1]));
  cover property (S_AXI_BVALID_O && S_AXI_BRESP_O == cpt_pkg::RESP_SLVERR);
endmodule

// ### cpt_field.sv
// Field signal source that drives pulse bursts onto the counter inputs.
// Assumes one caller at a time; the line idles low like a pulled-down input.
`timescale 1ns/1ps
module cpt_field (
  input wire logic clk_i,
  output logic pin_o
);
  initial pin_o = 1'b0;
  task automatic pulses(input int n, input int hi, input int lo);
    repeat (n) begin
      pin_o <= 1'b1;
      repeat (hi) @(posedge clk_i);
      pin_o <= 1'b0;
      repeat (lo) @(posedge clk_i);
    end
  endtask
endmodule

// ### cpt_top_tb.sv
// Bench of the counter unit: register bus tasks and field pulse source.
// Assumes cpt_pkg, cpt_top, cpt_chk and cpt_field are compiled first.
`timescale 1ns/1ps
module cpt_top_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, s_rdata, d;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, int_o, pin;
  logic [1:0] bresp, rresp, r, cnt_out;
  int n_errors = 0, comparisons = 0, k;
  always #12.5 clk = ~clk;
  cpt_field cpt_field_i (.clk_i(clk), .pin_o(pin));
  // Short gate keeps frequency runs brief
  cpt_top #(.NUM_CH(2), .GATE_CYCLES(400)) cpt_top_i (.CLK_SYS_I(clk), .RST_I(rst),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
    .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
    .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(s_rdata), .S_AXI_RRESP_O(rresp),
    .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .CNT_IN_I({pin, pin}),
    .CNT_OUT_O(cnt_out), .INT_O(int_o));
  task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    comparisons++;
    if ($isunknown(got) || got < lo || got > hi) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, lo);
    end
  endtask
  // Ready lines stay high between transfers; the watchdog ends a hung wait
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    chk(32'(bresp), 32'(er), 32'(er));
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rr);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = s_rdata;
    rr = rresp;
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    rd(a, d, r);
    chk(d, e, e);
    chk(32'(r), 32'h0, 32'h0);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rc(12'h040, 32'h0);
    rc(12'h04C, 32'h2);
    rc(12'h050, 32'h2);
    rc(12'h054, 32'h4);
    rc(12'h004, 32'h0);
    rd(12'h008, d, r);
    chk(d, 32'h0, 32'h0);
    chk(32'(r), 32'h2, 32'h2);
    wr(12'h008, 32'h1, cpt_pkg::RESP_SLVERR);
    $display("test registers done");
    wr(12'h044, 32'h3, cpt_pkg::RESP_OKAY);
    wr(12'h004, 32'h1, cpt_pkg::RESP_OKAY);
    wr(12'h040, 32'h90, cpt_pkg::RESP_OKAY);
    wr(12'h060, 32'h18, cpt_pkg::RESP_OKAY);
    cpt_field_i.pulses(5, 4, 4);
    repeat (6) @(posedge clk);
    rc(12'h048, 32'h5);
    rc(12'h068, 32'h5);
    chk(32'(int_o), 32'h1, 32'h1);
    rc(12'h000, 32'h1);
    repeat (3) @(posedge clk);
    chk(32'(int_o), 32'h0, 32'h0);
    wr(12'h040, 32'h0, cpt_pkg::RESP_OKAY);
    wr(12'h060, 32'h0, cpt_pkg::RESP_OKAY);
    $display("test event count done");
    // Divide ratio below four must behave as four
    wr(12'h054, 32'h2, cpt_pkg::RESP_OKAY);
    wr(12'h004, 32'h2, cpt_pkg::RESP_OKAY);
    wr(12'h040, 32'h14, cpt_pkg::RESP_OKAY);
    repeat (20) @(posedge clk);
    k = 0;
    repeat (80) begin
      @(posedge clk);
      if (cnt_out[0]) k++;
    end
    chk(32'(k), 32'd10, 32'd10);
    chk(32'(int_o), 32'h1, 32'h1);
    wr(12'h040, 32'h0, cpt_pkg::RESP_OKAY);
    rc(12'h000, 32'h2);
    $display("test timer done");
    wr(12'h06C, 32'h2, cpt_pkg::RESP_OKAY);
    wr(12'h070, 32'h3, cpt_pkg::RESP_OKAY);
    wr(12'h060, 32'h53, cpt_pkg::RESP_OKAY);
    k = 0;
    while (!cnt_out[1] && k < 100) begin
      @(posedge clk);
      k++;
    end
    k = 0;
    while (cnt_out[1] && k < 10000) begin
      @(posedge clk);
      k++;
    end
    chk(32'(k), 32'd3999, 32'd4001);
    repeat (7000) @(posedge clk);
    chk(32'(cnt_out[1]), 32'h0, 32'h0);
    wr(12'h060, 32'h0, cpt_pkg::RESP_OKAY);
    $display("test single pulse done");
    wr(12'h040, 32'h11, cpt_pkg::RESP_OKAY);
    cpt_field_i.pulses(60, 10, 10);
    rd(12'h048, d, r);
    chk(d, 32'd19, 32'd21);
    wr(12'h060, 32'h12, cpt_pkg::RESP_OKAY);
    cpt_field_i.pulses(4, 40, 40);
    rd(12'h068, d, r);
    chk(d, 32'd19, 32'd21);
    // Same channel, now timing the low level between pulses
    wr(12'h060, 32'h32, cpt_pkg::RESP_OKAY);
    cpt_field_i.pulses(4, 40, 40);
    rd(12'h068, d, r);
    chk(d, 32'd19, 32'd21);
    $display("test measurement done");
    results();
  end
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    results();
  end
endmodule
bind cpt_top cpt_chk #(.NUM_CH(NUM_CH)) cpt_chk_i (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I),
  .S_AXI_AWADDR_I(S_AXI_AWADDR_I), .S_AXI_AWVALID_I(S_AXI_AWVALID_I),
  .S_AXI_AWREADY_O(S_AXI_AWREADY_O), .S_AXI_WVALID_I(S_AXI_WVALID_I),
  .S_AXI_WREADY_O(S_AXI_WREADY_O), .S_AXI_BRESP_O(S_AXI_BRESP_O),
  .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_BREADY_I(S_AXI_BREADY_I),
  .S_AXI_ARADDR_I(S_AXI_ARADDR_I), .S_AXI_ARVALID_I(S_AXI_ARVALID_I),
  .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_RDATA_O(S_AXI_RDATA_O),
  .S_AXI_RRESP_O(S_AXI_RRESP_O), .S_AXI_RVALID_O(S_AXI_RVALID_O),
  .S_AXI_RREADY_I(S_AXI_RREADY_I), .CNT_OUT_O(CNT_OUT_O), .INT_O(INT_O));
